//--- shared/btc_pkg.sv
// Shared types and constants for the bus cycle termination block
package btc_pkg;

  // Core clocks between two even bus states (N to N+2)
  localparam int unsigned SAMPLE_DIV = 1;
  localparam int unsigned DIV_W      = 4;

  // Exception vectors and their table offsets
  localparam logic [7:0] VEC_NUM_FAULT   = 8'h02;
  localparam logic [7:0] VEC_OFF_FAULT   = 8'h08;
  localparam logic [7:0] VEC_NUM_ILLEGAL = 8'h00;
  localparam logic [7:0] VEC_OFF_ILLEGAL = 8'h00;

  // Variant selection: 0 basic, 1 late error detection after acknowledge
  localparam bit LATE_FAULT_DEF = 1'b0;

  // Termination inputs, active low as on the pins
  typedef struct packed {
    logic transfer_ack_n;
    logic bus_fault_n;
    logic halt_req_n;
  } btc_pins_s;

  // All three inputs negated
  localparam btc_pins_s PINS_IDLE = '{transfer_ack_n: 1'b1, bus_fault_n: 1'b1, halt_req_n: 1'b1};

  // Gray codes along idle, sample, confirm and the waits
  typedef enum logic [2:0] {
    ST_IDLE       = 3'h0,
    ST_SAMPLE     = 3'h1,
    ST_CONFIRM    = 3'h3,
    ST_HALT_WAIT  = 3'h2,
    ST_RETRY_WAIT = 3'h6,
    ST_TRAP_WAIT  = 3'h7
  } btc_state_e;

  typedef enum logic [2:0] {
    OUT_NONE    = 3'h0,
    OUT_NORMAL  = 3'h1,
    OUT_HALT    = 3'h2,
    OUT_TRAP    = 3'h3,
    OUT_RETRY   = 3'h4,
    OUT_ILLEGAL = 3'h5
  } btc_outcome_e;

endpackage

//--- verilog/btc_sync.sv
// Two-stage synchroniser for the termination input pins
`timescale 1ns/100ps
module btc_sync
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire btc_pkg::btc_pins_s pins_in,
  output      btc_pkg::btc_pins_s pins_out
);

  typedef struct packed {
    btc_pkg::btc_pins_s meta;
    btc_pkg::btc_pins_s stable;
  } btc_sync_s;

  btc_sync_s s_r;
  btc_sync_s s_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.meta   = pins_in;
    s_nxt.stable = s_r.meta;
  end

  // Reset to negated so no phantom termination at start-up
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r <= '{meta: btc_pkg::PINS_IDLE, stable: btc_pkg::PINS_IDLE};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pins_out = s_r.stable;

endmodule

//--- verilog/btc_term.sv
// Bus cycle termination decision logic
// Overview of operation
// - Inputs are sampled at even state N and N+2; outcome uses both.
// - Acknowledge alone ends the cycle normally and continues.
// - Halt with or before acknowledge: normal end, then halt until halt negates.
// - Fault with or before acknowledge, no halt: abort and take fault trap.
// - Fault only at N+2 after acknowledge: basic ends normally, late variant traps.
// - Fault and halt with or before acknowledge: abort, retry after halt negates.
// - Fault and halt only at N+2: basic ends normally, late variant retries.
// - Wrong release order during rerun traps through vector number 0.
// - Fault still asserted at next cycle start ends that cycle as fault.
// - Fault abort fetches vector entry 2 at offset 08 and starts handler.
// - Retry floats address and data until halt negates, then repeats the cycle.
// - Read-modify-write cycles never retry; a fault that aborts one traps.
`timescale 1ns/100ps
module btc_term
#(
  parameter bit          LATE_FAULT_EN = btc_pkg::LATE_FAULT_DEF,
  parameter int unsigned SAMPLE_DIV    = btc_pkg::SAMPLE_DIV
)
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 transfer_ack_n,
  input  wire logic                 bus_fault_n,
  input  wire logic                 halt_req_n,
  input  wire logic                 cycle_start,
  input  wire logic                 rmw_cycle,
  output      logic                 cycle_done,
  output      btc_pkg::btc_outcome_e cycle_outcome,
  output      logic                 trap_req,
  output      logic [7:0]           trap_vec_off,
  output      logic                 rerun_req,
  output      logic                 bus_float,
  output      logic                 cpu_halted
);
  typedef struct packed {
    btc_pkg::btc_state_e   state;
    logic [btc_pkg::DIV_W-1:0] div_cnt;
    logic                  n_ack;
    logic                  n_fault;
    logic                  n_halt;
    logic                  halt_seen;
    logic                  rmw;
    logic                  fault_clr;
    logic                  done;
    btc_pkg::btc_outcome_e outcome;
    logic                  trap;
    logic [7:0]            vec;
    logic                  rerun;
    logic                  flt;
    logic                  halted;
  } btc_term_s;
  localparam logic [btc_pkg::DIV_W-1:0] DIV_LAST = btc_pkg::DIV_W'(SAMPLE_DIV - 1);
  btc_pkg::btc_pins_s pins_sync;
  btc_term_s          s_r;
  btc_term_s          s_nxt;
  logic               p_ack;
  logic               p_fault;
  logic               p_halt;
  logic               sample_en;
  // Pins come from another party, so two flops before any decision
  btc_sync i_btc_sync
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pins_in  ({transfer_ack_n, bus_fault_n, halt_req_n}),
    .pins_out (pins_sync)
  );
  // Asserted-high views of the synchronised pins
  assign p_ack     = ~pins_sync.transfer_ack_n;
  assign p_fault   = ~pins_sync.bus_fault_n;
  assign p_halt    = ~pins_sync.halt_req_n;
  assign sample_en = (s_r.div_cnt == DIV_LAST);
  // Abort kind: read-modify-write never retries, so halt is moot there
  function automatic btc_pkg::btc_outcome_e abort_kind(input logic halt, input logic rmw);
    abort_kind = (halt && !rmw) ? btc_pkg::OUT_RETRY : btc_pkg::OUT_TRAP;
  endfunction
  // Next-state logic
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.done    = 1'b0;
    s_nxt.trap    = 1'b0;
    s_nxt.rerun   = 1'b0;
    s_nxt.div_cnt = sample_en ? '0 : s_r.div_cnt + 1'b1;
    case (s_r.state)
      btc_pkg::ST_IDLE:
      begin
        s_nxt.div_cnt = '0;
        if (cycle_start)
        begin
          s_nxt.rmw       = rmw_cycle;
          s_nxt.halt_seen = 1'b0;
          s_nxt.state     = btc_pkg::ST_SAMPLE;
          // Leftover fault from the last cycle ends this one at once
          if (p_fault)
          begin
            s_nxt.done    = 1'b1;
            s_nxt.outcome = btc_pkg::OUT_TRAP;
            s_nxt.trap    = 1'b1;
            s_nxt.vec     = btc_pkg::VEC_OFF_FAULT;
            s_nxt.flt     = 1'b1;
            s_nxt.state   = btc_pkg::ST_TRAP_WAIT;
          end
        end
      end
      btc_pkg::ST_SAMPLE:
      begin
        // Even state N: wait states until acknowledge or fault
        if (sample_en)
        begin
          s_nxt.n_ack     = p_ack;
          s_nxt.n_fault   = p_fault;
          s_nxt.n_halt    = p_halt;
          s_nxt.halt_seen = s_r.halt_seen | p_halt;
          if (p_ack || p_fault)
          begin
            s_nxt.state = btc_pkg::ST_CONFIRM;
          end
        end
      end
      btc_pkg::ST_CONFIRM:
      begin
        // Even state N+2: resolve the outcome
        if (sample_en)
        begin
          s_nxt.done = 1'b1;
          if (s_r.n_fault)
          begin
            s_nxt.outcome = abort_kind(s_r.n_halt | p_halt, s_r.rmw);
          end
          else if (LATE_FAULT_EN && p_fault)
          begin
            s_nxt.outcome = abort_kind(p_halt, s_r.rmw);
          end
          else if (s_r.halt_seen)
          begin
            s_nxt.outcome = btc_pkg::OUT_HALT;
          end
          else
          begin
            s_nxt.outcome = btc_pkg::OUT_NORMAL;
          end
          case (s_nxt.outcome)
            btc_pkg::OUT_TRAP:
            begin
              s_nxt.trap  = 1'b1;
              s_nxt.vec   = btc_pkg::VEC_OFF_FAULT;
              s_nxt.flt   = 1'b1;
              s_nxt.state = btc_pkg::ST_TRAP_WAIT;
            end
            btc_pkg::OUT_RETRY:
            begin
              s_nxt.flt       = 1'b1;
              s_nxt.fault_clr = 1'b0;
              s_nxt.state     = btc_pkg::ST_RETRY_WAIT;
            end
            btc_pkg::OUT_HALT:
            begin
              s_nxt.halted = 1'b1;
              s_nxt.flt    = 1'b1;
              s_nxt.state  = btc_pkg::ST_HALT_WAIT;
            end
            default:
            begin
              s_nxt.state = btc_pkg::ST_IDLE;
            end
          endcase
        end
      end
      btc_pkg::ST_HALT_WAIT:
      begin
        // Stay halted and off the bus until halt is released
        if (!p_halt)
        begin
          s_nxt.halted = 1'b0;
          s_nxt.flt    = 1'b0;
          s_nxt.state  = btc_pkg::ST_IDLE;
        end
      end
      btc_pkg::ST_RETRY_WAIT:
      begin
        if (!p_fault)
        begin
          s_nxt.fault_clr = 1'b1;
        end
        if (!p_halt)
        begin
          // Halt must outlast fault by a cycle, else the rerun is unsafe
          if (p_fault || !s_r.fault_clr)
          begin
            s_nxt.done    = 1'b1;
            s_nxt.outcome = btc_pkg::OUT_ILLEGAL;
            s_nxt.trap    = 1'b1;
            s_nxt.vec     = btc_pkg::VEC_OFF_ILLEGAL;
            s_nxt.state   = p_fault ? btc_pkg::ST_TRAP_WAIT : btc_pkg::ST_IDLE;
            s_nxt.flt     = p_fault;
          end
          else
          begin
            s_nxt.rerun     = 1'b1;
            s_nxt.flt       = 1'b0;
            s_nxt.halt_seen = 1'b0;
            s_nxt.div_cnt   = '0;
            s_nxt.state     = btc_pkg::ST_SAMPLE;
          end
        end
      end
      btc_pkg::ST_TRAP_WAIT:
      begin
        // Bus stays floated while fault is held
        if (!p_fault)
        begin
          s_nxt.flt   = 1'b0;
          s_nxt.state = btc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_nxt.state = btc_pkg::ST_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r <= '{state: btc_pkg::ST_IDLE, outcome: btc_pkg::OUT_NONE, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  // Outputs come straight from state flops
  assign cycle_done    = s_r.done;
  assign cycle_outcome = s_r.outcome;
  assign trap_req      = s_r.trap;
  assign trap_vec_off  = s_r.vec;
  assign rerun_req     = s_r.rerun;
  assign bus_float     = s_r.flt;
  assign cpu_halted    = s_r.halted;
  // Checks on the decision logic
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_done_one_cycle: assert property (s_r.done |=> !s_r.done)
    else $error("done held longer than one cycle");
  a_ack_normal_end: assert property ((s_r.state == btc_pkg::ST_CONFIRM) && sample_en && s_r.n_ack
    && !s_r.n_fault && !s_r.halt_seen && !p_fault |=> cycle_done
    && cycle_outcome == btc_pkg::OUT_NORMAL)
    else $error("plain acknowledge did not end normally");
  a_halt_stays: assert property ((s_r.state == btc_pkg::ST_HALT_WAIT) && p_halt
    |=> cpu_halted && bus_float)
    else $error("halt released while halt still asserted");
  a_early_fault_abort: assert property ((s_r.state == btc_pkg::ST_CONFIRM) && sample_en
    && s_r.n_fault |=> cycle_done && (trap_req ^ (s_r.state == btc_pkg::ST_RETRY_WAIT)))
    else $error("early fault did not abort");
  a_basic_late_ok: assert property (!LATE_FAULT_EN && (s_r.state == btc_pkg::ST_CONFIRM)
    && sample_en && !s_r.n_fault |=> !trap_req && !bus_float
    || cycle_outcome == btc_pkg::OUT_HALT)
    else $error("basic variant acted on late fault");
  a_late_fault_acts: assert property (LATE_FAULT_EN && (s_r.state == btc_pkg::ST_CONFIRM)
    && sample_en && s_r.n_ack && p_fault |=> bus_float)
    else $error("late variant ignored late fault");
  a_rmw_no_retry: assert property (cycle_done && s_r.rmw
    |-> cycle_outcome != btc_pkg::OUT_RETRY)
    else $error("read-modify-write cycle was retried");
  a_trap_vector: assert property (trap_req && cycle_outcome == btc_pkg::OUT_TRAP
    |-> trap_vec_off == btc_pkg::VEC_OFF_FAULT)
    else $error("fault trap used wrong vector offset");
  a_illegal_vec0: assert property ((s_r.state == btc_pkg::ST_RETRY_WAIT) && !p_halt && p_fault
    |=> trap_req && trap_vec_off == btc_pkg::VEC_OFF_ILLEGAL)
    else $error("bad release order did not trap to vector 0");
  a_rerun_follows: assert property ((s_r.state == btc_pkg::ST_RETRY_WAIT) && s_r.fault_clr
    && !p_fault && !p_halt |=> rerun_req ##1 !bus_float)
    else $error("rerun not issued after halt release");
  a_leftover_fault: assert property ((s_r.state == btc_pkg::ST_IDLE) && cycle_start && p_fault
    |=> trap_req && cycle_outcome == btc_pkg::OUT_TRAP)
    else $error("leftover fault did not end next cycle");

  c_normal: cover property (cycle_done && cycle_outcome == btc_pkg::OUT_NORMAL);
  c_retry:  cover property (rerun_req);
  c_trap:   cover property (trap_req && cycle_outcome == btc_pkg::OUT_TRAP);
  c_halt:   cover property (cpu_halted ##1 !cpu_halted);

endmodule

//--- testbench/btc_slave_model.sv
// Behavioural slave, watchdog and halt source driving the termination pins
`timescale 1ns/100ps
module btc_slave_model
(
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic            go,
  input  wire logic [6:0][4:0] win,
  output      logic            transfer_ack_n,
  output      logic            bus_fault_n,
  output      logic            halt_req_n
);
  logic [4:0] cnt_r;
  logic       act_r;

  // True while the step counter sits inside [lo, hi)
  function automatic logic in_win(input logic [4:0] lo, input logic [4:0] hi);
    return act_r && cnt_r >= lo && cnt_r < hi;
  endfunction

  // Step counter; saturates so a finished pattern stays released
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r <= 5'h00;
      act_r <= 1'b0;
    end
    else if (go)
    begin
      cnt_r <= 5'h00;
      act_r <= 1'b1;
    end
    else if (cnt_r != 5'h1F)
    begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Pins move just after a rising edge; released pins float high on pull-ups
  always_comb
  begin
    transfer_ack_n = !(in_win(win[0], win[1]) || in_win(win[2], win[2] + 5'h04));
    bus_fault_n    = !in_win(win[3], win[4]);
    halt_req_n     = !in_win(win[5], win[6]);
  end
endmodule

//--- testbench/tb_btc_term.sv
// Self-checking bench running basic and late-fault variants side by side
`timescale 1ns/100ps
module tb_btc_term;
  localparam btc_pkg::btc_outcome_e NO = btc_pkg::OUT_NONE;
  localparam btc_pkg::btc_outcome_e NM = btc_pkg::OUT_NORMAL;
  localparam btc_pkg::btc_outcome_e HT = btc_pkg::OUT_HALT;
  localparam btc_pkg::btc_outcome_e TR = btc_pkg::OUT_TRAP;
  localparam btc_pkg::btc_outcome_e RT = btc_pkg::OUT_RETRY;
  localparam btc_pkg::btc_outcome_e IL = btc_pkg::OUT_ILLEGAL;

  logic                  core_clk;
  logic                  sys_rst;
  logic                  cycle_start;
  logic                  rmw_cycle;
  logic                  go;
  logic [6:0][4:0]       win;
  logic                  ack_n;
  logic                  fault_n;
  logic                  halt_n;
  logic                  done [2];
  btc_pkg::btc_outcome_e outc [2];
  logic                  trp  [2];
  logic [7:0]            vec  [2];
  logic                  rr   [2];
  logic                  flt  [2];
  logic                  hlt  [2];
  btc_pkg::btc_outcome_e q    [2][$];
  btc_pkg::btc_outcome_e exp_o;
  int                    n_rr [2];
  int                    n_fail = 0;
  int                    tests_run = 0;
  int                    d;

  btc_slave_model i_btc_slave_model
  (
    .core_clk       (core_clk),
    .sys_rst        (sys_rst),
    .go             (go),
    .win            (win),
    .transfer_ack_n (ack_n),
    .bus_fault_n    (fault_n),
    .halt_req_n     (halt_n)
  );

  // Index 0 is the basic variant, index 1 the late-fault variant
  for (genvar g = 0; g < 2; g++)
  begin : g_var
    btc_term #(.LATE_FAULT_EN(g == 1)) i_btc_term
    (
      .core_clk       (core_clk),
      .sys_rst        (sys_rst),
      .transfer_ack_n (ack_n),
      .bus_fault_n    (fault_n),
      .halt_req_n     (halt_n),
      .cycle_start    (cycle_start),
      .rmw_cycle      (rmw_cycle),
      .cycle_done     (done[g]),
      .cycle_outcome  (outc[g]),
      .trap_req       (trp[g]),
      .trap_vec_off   (vec[g]),
      .rerun_req      (rr[g]),
      .bus_float      (flt[g]),
      .cpu_halted     (hlt[g])
    );
  end

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Oldest note is taken whenever a variant reports a decision or a trap
  always @(posedge core_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rr[i] === 1'b1)
        n_rr[i]++;
      if (done[i] === 1'b1 || trp[i] === 1'b1)
      begin
        exp_o = (q[i].size() > 0) ? q[i].pop_front() : NO;
        check("outcome", 8'(outc[i]), 8'(exp_o));
        check("trap", {7'h00, trp[i]}, {7'h00, exp_o inside {TR, IL}});
        if (trp[i] === 1'b1)
          check("vector", vec[i], (exp_o == IL) ? 8'h00 : btc_pkg::VEC_OFF_FAULT);
      end
    end
  end

  // Pin windows [on, off) per signal, 31 never; ext starts a second cycle
  task automatic run(input int a0, a1, r0, f0, f1, h0, h1, input logic rmw, ext,
                     input btc_pkg::btc_outcome_e b0, b1, l0, l1);
    btc_pkg::btc_outcome_e el [4];
    el = '{b0, b1, l0, l1};
    @(negedge core_clk);
    win = {5'(h1), 5'(h0), 5'(f1), 5'(f0), 5'(r0), 5'(a1), 5'(a0)};
    n_rr = '{0, 0};
    for (int k = 0; k < 4; k++)
      if (el[k] != NO)
        q[k / 2].push_back(el[k]);
    rmw_cycle = rmw;
    cycle_start = 1'b1;
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    for (int c = 1; c < 30; c++)
    begin
      cycle_start = (c == 12) && ext;
      @(negedge core_clk);
      if (c == 8 && (b0 == HT || (b0 == RT && b1 == NM)))
      begin
        check("float", {7'h00, flt[0]}, 8'h01);
        check("halted", {7'h00, hlt[0]}, {7'h00, b0 == HT});
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      check("idle float", {7'h00, flt[i]}, 8'h00);
      check("pending", 8'(q[i].size()), 8'h00);
      check("reruns", 8'(n_rr[i]), {7'h00, el[2 * i] == RT && el[2 * i + 1] == NM});
    end
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    cycle_start = 1'b0;
    rmw_cycle = 1'b0;
    go = 1'b0;
    win = '1;
    d = $urandom(93);
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    run(0, 4, 31, 31, 31, 31, 31, 0, 0, NM, NO, NM, NO);
    run(0, 4, 31, 31, 31, 0, 10, 0, 0, HT, NO, HT, NO);
    run(3, 7, 31, 31, 31, 0, 10, 0, 0, HT, NO, HT, NO);
    run(2, 6, 31, 2, 6, 31, 31, 0, 0, TR, NO, TR, NO);
    run(0, 4, 31, 1, 5, 31, 31, 0, 0, NM, NO, TR, NO);
    run(31, 31, 8, 0, 4, 0, 6, 0, 0, RT, NM, RT, NM);
    run(0, 4, 10, 1, 5, 1, 7, 0, 0, NM, NO, RT, NM);
    run(31, 31, 31, 0, 6, 0, 4, 0, 0, RT, IL, RT, IL);
    run(31, 31, 31, 0, 4, 0, 6, 1, 0, TR, NO, TR, NO);
    run(0, 4, 31, 8, 20, 31, 31, 0, 1, NM, TR, NM, TR);
    // Random wait states for plain and watchdog terminations
    repeat (6)
    begin
      d = $urandom_range(5, 0);
      if ($urandom_range(1, 0) == 1)
        run(d, d + 4, 31, 31, 31, 31, 31, 0, 0, NM, NO, NM, NO);
      else
        run(31, 31, 31, d, d + 4, 31, 31, 0, 0, TR, NO, TR, NO);
    end
    finish_test();
  end

  // Hang guard, well beyond the roughly 500 cycles the sequence needs
  initial
  begin
    #50000;
    n_fail++;
    finish_test();
  end
endmodule
